// ### crm_pkg.sv
// Purpose: shared constants and types of the command/response decoder
// Assumes: 32-bit commands arrive as whole words from a same-clock receiver
// Notes:   chips are coded 0 = quiescent, 1 = one step, 2 = two steps
package crm_pkg;
    // ************************************************************
    // frame layout
    // ************************************************************
    localparam int          CMD_W      = 32;
    localparam int          NIB_W      = 4;
    localparam int          BYTE_W     = 8;
    localparam int          CRC_W      = 8;
    localparam int          ADDR_LSB   = 28;   // node address field
    localparam int          CODE_LSB   = 24;   // command code field
    localparam int          EXT_LSB    = 16;   // extended data field
    localparam int          DATA_LSB   = 8;    // register data field
    localparam int          PAIR_LSB   = 17;   // pair address, bits 23..17
    localparam int          PAIR_W     = 7;
    localparam int          RESP_W     = 24;   // response without checksum
    localparam int          CNT_W      = 6;
    localparam logic [5:0]  BIT_LAST   = 6'h1F;   // 32 bits per pass
    localparam logic [3:0]  NIB_COUNT  = 4'h8;    // nibbles per response
    localparam logic [1:0]  CHIP_LAST  = 2'h2;    // three chips per symbol
    localparam logic [1:0]  LVL_Q      = 2'h0;
    localparam logic [3:0]  ADDR_GLOBAL = 4'h0;
    // ************************************************************
    // checksum and command codes
    // ************************************************************
    localparam logic [7:0]  CRC_POLY   = 8'h2F;   // x8+x5+x3+x2+x+1
    localparam logic [7:0]  CRC_SEED   = 8'hFF;
    localparam logic [7:0]  BYTE_ZERO  = 8'h00;
    localparam logic [3:0]  CMD_READ   = 4'h0;
    localparam logic [3:0]  CMD_WRITE  = 4'h8;
    localparam logic [3:0]  CMD_PERIODIC_COLLECTION_MODE   = 4'hB;
    // ************************************************************
    // nibble to chip table, {chip1, chip2, chip3}
    // ************************************************************
    localparam logic [5:0]  SYM_TAB [16] = '{
        6'h14, 6'h25, 6'h12, 6'h22, 6'h10, 6'h26, 6'h16, 6'h21,
        6'h28, 6'h24, 6'h1A, 6'h29, 6'h18, 6'h20, 6'h11, 6'h19};

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_CHECK = 3'b001,
        ST_EXEC  = 3'b010,
        ST_READ  = 3'b011,
        ST_GEN   = 3'b100,
        ST_LOAD  = 3'b101,
        ST_SEND  = 3'b110
    } crm_state_t;
endpackage

// ### crm_crc_if.sv
// Purpose: carrier between the sequencer and the serial checksum engine
// Assumes: one clock domain
// Notes:   crc is the engine's register, valid the cycle after a shift
`timescale 1ns/1ps
interface crm_crc_if;
    logic       clr;
    logic       shift;
    logic       din;
    logic [7:0] crc;
    modport eng (input clr, input shift, input din, output crc);
    modport ctl (output clr, output shift, output din, input crc);
endinterface

// ### crm_crc_serial.sv
// Purpose: bit-serial 8-bit checksum register
// Assumes: clr and shift are never wanted in the same cycle; clr wins
// Notes:   a check pass ends at zero, a generate pass ends at the checksum
`timescale 1ns/1ps
module crm_crc_serial
(
    input  wire logic   core_clk,
    input  wire logic   rstn,
    crm_crc_if.eng      bus
);
    logic [7:0] crc_ff;
    logic [7:0] nxt_crc;

    // ************************************************************
    // shift step
    // ************************************************************
    // message enters the low bit, feedback taps from the top bit
    assign nxt_crc = {crc_ff[crm_pkg::CRC_W-2:0], bus.din}
                   ^ (crc_ff[crm_pkg::CRC_W-1] ? crm_pkg::CRC_POLY : crm_pkg::BYTE_ZERO);
    assign bus.crc = crc_ff;

    // seed goes into the whole register before each pass
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            crc_ff <= crm_pkg::CRC_SEED;
        else if (bus.clr)
            crc_ff <= crm_pkg::CRC_SEED;
        else if (bus.shift)
            crc_ff <= nxt_crc;
    end

    AST_CRC_SEED: assert property (@(posedge core_clk) disable iff (!rstn)
        bus.clr |=> crc_ff == crm_pkg::CRC_SEED)
        else $error("checksum not seeded");
    AST_CRC_HOLD: assert property (@(posedge core_clk) disable iff (!rstn)
        !bus.clr && !bus.shift |=> $stable(crc_ff))
        else $error("checksum moved without a shift");
endmodule

// ### crm_cmd_resp.sv
// Purpose: command decode and response build for command/response mode
// Assumes: commands come as 32-bit words with valid/ready on core_clk;
//          the register array answers reads combinationally
// Notes:   chip_level is the drive step of the response current source
`timescale 1ns/1ps
module crm_cmd_resp
#(
    parameter int CHIP_CYCLES = 50   // core cycles per chip
)
(
    input  wire logic        core_clk,
    input  wire logic        rstn,
    input  wire logic        cmd_valid,
    input  wire logic [31:0] cmd_word,
    output logic             cmd_ready,
    input  wire logic [3:0]  node_address_register,
    output logic [6:0]       reg_pair_address,
    input  wire logic [7:0]  upper_reg_data_byte,
    input  wire logic [7:0]  lower_reg_data_byte,
    input  wire logic        upper_readable,
    input  wire logic        lower_readable,
    output logic             reg_wr_en,
    output logic [7:0]       reg_byte_address,
    output logic [7:0]       reg_wr_data,
    output logic [1:0]       chip_level,
    output logic             resp_active,
    output logic             periodic_collection_mode
);
    localparam logic [15:0] DIV_LAST = 16'(CHIP_CYCLES - 1);

    crm_pkg::crm_state_t state_ff;
    crm_pkg::crm_state_t nxt_state;
    logic [31:0] cmd_ff;
    logic [31:0] sh_ff;
    logic [23:0] resp_ff;
    logic [31:0] tx_ff;
    logic [5:0]  bit_cnt_ff;
    logic [3:0]  nib_cnt_ff;
    logic [1:0]  chip_idx_ff;
    logic [15:0] div_ff;
    logic [1:0]  chip_level_ff;
    logic        periodic_collection_mode_ff;

    crm_crc_if crc_bus();

    crm_crc_serial u_crc
    (
        .core_clk (core_clk),
        .rstn     (rstn),
        .bus      (crc_bus)
    );

    // ************************************************************
    // decode
    // ************************************************************
    // picks one chip of a symbol; chip 0 is the first sent
    function automatic logic [1:0] crm_pick(input logic [5:0] sym, input logic [1:0] idx);
        logic [1:0] lvl;
        lvl = sym[1:0];
        if (idx == 2'h0)
            lvl = sym[5:4];
        else if (idx == 2'h1)
            lvl = sym[3:2];
        return lvl;
    endfunction

    // field split of the held command word
    logic [3:0] cmd_addr;
    logic [3:0] cmd_code;
    logic       crc_good;
    logic       addr_match;
    logic       cmd_ok;
    logic       is_read;
    logic       is_write;
    logic       is_periodic_collection_mode;
    logic       capture;
    logic [7:0] hi_data;
    logic [7:0] lo_data;
    logic       chip_en;
    logic       last_bit;
    logic [1:0] sel_level;
    assign cmd_addr   = cmd_ff[crm_pkg::ADDR_LSB +: crm_pkg::NIB_W];
    assign cmd_code   = cmd_ff[crm_pkg::CODE_LSB +: crm_pkg::NIB_W];
    assign crc_good   = crc_bus.crc == crm_pkg::BYTE_ZERO;
    // a zero node address would alias the global address, so it never matches
    assign addr_match = (cmd_addr == node_address_register)
                      && (cmd_addr != crm_pkg::ADDR_GLOBAL);
    assign cmd_ok     = crc_good && addr_match && (state_ff == crm_pkg::ST_EXEC);
    assign is_read    = cmd_code == crm_pkg::CMD_READ;
    assign is_write   = cmd_code == crm_pkg::CMD_WRITE;
    assign is_periodic_collection_mode    = cmd_code == crm_pkg::CMD_PERIODIC_COLLECTION_MODE;
    assign capture    = (cmd_ok && is_read) || (state_ff == crm_pkg::ST_READ);
    assign hi_data    = upper_readable ? upper_reg_data_byte : crm_pkg::BYTE_ZERO;
    assign lo_data    = lower_readable ? lower_reg_data_byte : crm_pkg::BYTE_ZERO;
    assign last_bit   = bit_cnt_ff == crm_pkg::BIT_LAST;
    assign chip_en    = div_ff == DIV_LAST;
    assign sel_level  = crm_pick(crm_pkg::SYM_TAB[tx_ff[crm_pkg::CMD_W-1 -: crm_pkg::NIB_W]],
                                 chip_idx_ff);

    // register port: write address/data and read pair come from the command
    assign reg_pair_address = cmd_ff[crm_pkg::PAIR_LSB +: crm_pkg::PAIR_W];
    assign reg_byte_address = cmd_ff[crm_pkg::EXT_LSB +: crm_pkg::BYTE_W];
    assign reg_wr_data      = cmd_ff[crm_pkg::DATA_LSB +: crm_pkg::BYTE_W];
    assign reg_wr_en        = cmd_ok && is_write;

    // checksum engine steering: serial bits always come from the top of sh_ff
    assign crc_bus.clr   = (state_ff == crm_pkg::ST_IDLE) || capture;
    assign crc_bus.shift = (state_ff == crm_pkg::ST_CHECK) || (state_ff == crm_pkg::ST_GEN);
    assign crc_bus.din   = sh_ff[crm_pkg::CMD_W-1];

    assign cmd_ready   = (state_ff == crm_pkg::ST_IDLE) && !periodic_collection_mode_ff;
    assign resp_active = state_ff == crm_pkg::ST_SEND;
    assign chip_level  = chip_level_ff;
    assign periodic_collection_mode = periodic_collection_mode_ff;

    // ************************************************************
    // sequencer
    // ************************************************************
    // next state; every rejected command falls straight back to idle
    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            crm_pkg::ST_IDLE:
                if (cmd_valid && cmd_ready)
                    nxt_state = crm_pkg::ST_CHECK;
            crm_pkg::ST_CHECK:
                if (last_bit)
                    nxt_state = crm_pkg::ST_EXEC;
            crm_pkg::ST_EXEC:
                if (cmd_ok && is_read)
                    nxt_state = crm_pkg::ST_GEN;
                else if (cmd_ok && is_write)
                    nxt_state = crm_pkg::ST_READ;   // read back after the write
                else
                    nxt_state = crm_pkg::ST_IDLE;
            crm_pkg::ST_READ:
                nxt_state = crm_pkg::ST_GEN;
            crm_pkg::ST_GEN:
                if (last_bit)
                    nxt_state = crm_pkg::ST_LOAD;
            crm_pkg::ST_LOAD:
                nxt_state = crm_pkg::ST_SEND;
            crm_pkg::ST_SEND:
                if (chip_en && (nib_cnt_ff == crm_pkg::NIB_COUNT))
                    nxt_state = crm_pkg::ST_IDLE;
            default:
                nxt_state = crm_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            state_ff <= crm_pkg::ST_IDLE;
        else
            state_ff <= nxt_state;
    end

    // periodic mode is sticky until reset; commands are refused from then on
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            periodic_collection_mode_ff <= 1'b0;
        else if (cmd_ok && is_periodic_collection_mode)
            periodic_collection_mode_ff <= 1'b1;
    end

    // ************************************************************
    // datapath
    // ************************************************************
    // command hold and serial shifter; generate pass appends eight zeros
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cmd_ff     <= '0;
            sh_ff      <= '0;
            resp_ff    <= '0;
            bit_cnt_ff <= '0;
        end
        else if (cmd_valid && cmd_ready)
        begin
            cmd_ff     <= cmd_word;
            sh_ff      <= cmd_word;
            bit_cnt_ff <= '0;
        end
        else if (capture)
        begin
            resp_ff    <= {node_address_register, cmd_code, hi_data, lo_data};
            sh_ff      <= {node_address_register, cmd_code, hi_data, lo_data,
                           crm_pkg::BYTE_ZERO};
            bit_cnt_ff <= '0;
        end
        else if (crc_bus.shift)
        begin
            sh_ff      <= {sh_ff[crm_pkg::CMD_W-2:0], 1'b0};
            bit_cnt_ff <= bit_cnt_ff + 6'h01;
        end
    end

    // chip divider and symbol stepping; the last chip is held a full period
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            tx_ff         <= '0;
            div_ff        <= '0;
            nib_cnt_ff    <= '0;
            chip_idx_ff   <= '0;
            chip_level_ff <= crm_pkg::LVL_Q;
        end
        else if (state_ff == crm_pkg::ST_LOAD)
        begin
            tx_ff       <= {resp_ff, crc_bus.crc};
            div_ff      <= DIV_LAST;                 // first chip starts at once
            nib_cnt_ff  <= '0;
            chip_idx_ff <= '0;
        end
        else if (state_ff == crm_pkg::ST_SEND)
        begin
            div_ff <= chip_en ? 16'h0000 : div_ff + 16'h0001;
            if (chip_en && (nib_cnt_ff == crm_pkg::NIB_COUNT))
                chip_level_ff <= crm_pkg::LVL_Q;
            else if (chip_en)
            begin
                chip_level_ff <= sel_level;
                chip_idx_ff   <= (chip_idx_ff == crm_pkg::CHIP_LAST) ? 2'h0 : chip_idx_ff + 2'h1;
                if (chip_idx_ff == crm_pkg::CHIP_LAST)
                begin
                    tx_ff      <= {tx_ff[crm_pkg::CMD_W-crm_pkg::NIB_W-1:0], 4'h0};
                    nib_cnt_ff <= nib_cnt_ff + 4'h1;
                end
            end
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    AST_BAD_CRC_DROP: assert property (@(posedge core_clk) disable iff (!rstn)
        (state_ff == crm_pkg::ST_EXEC) && !crc_good
        |-> !reg_wr_en ##1 state_ff == crm_pkg::ST_IDLE)
        else $error("bad checksum not dropped");
    AST_ADDR_MISS: assert property (@(posedge core_clk) disable iff (!rstn)
        (state_ff == crm_pkg::ST_EXEC) && !addr_match |=> state_ff == crm_pkg::ST_IDLE)
        else $error("foreign address answered");
    AST_RESV_IGNORE: assert property (@(posedge core_clk) disable iff (!rstn)
        (state_ff == crm_pkg::ST_EXEC) && !is_read && !is_write
        |-> !reg_wr_en ##1 state_ff == crm_pkg::ST_IDLE)
        else $error("reserved code acted on");
    AST_WRITE_THEN_READ: assert property (@(posedge core_clk) disable iff (!rstn)
        reg_wr_en |=> (state_ff == crm_pkg::ST_READ) ##1 (state_ff == crm_pkg::ST_GEN))
        else $error("write not followed by read back");
    AST_HEAD_FIELDS: assert property (@(posedge core_clk) disable iff (!rstn)
        capture |=> resp_ff[crm_pkg::RESP_W-1 -: crm_pkg::BYTE_W]
                    == {$past(node_address_register), $past(cmd_code)})
        else $error("response head wrong");
    AST_DATA_SAMPLE: assert property (@(posedge core_clk) disable iff (!rstn)
        capture |=> resp_ff[crm_pkg::BYTE_W*2-1:0] == {$past(hi_data), $past(lo_data)})
        else $error("response data wrong");
    // counted from the take edge, so a wrong bit counter end point is caught
    AST_CHECK_LEN: assert property (@(posedge core_clk) disable iff (!rstn)
        cmd_valid && cmd_ready |-> ##33 state_ff == crm_pkg::ST_EXEC)
        else $error("check pass length wrong");
    AST_CRC_APPEND: assert property (@(posedge core_clk) disable iff (!rstn)
        (state_ff == crm_pkg::ST_GEN) && last_bit
        |=> (state_ff == crm_pkg::ST_LOAD) ##1 (tx_ff[crm_pkg::CRC_W-1:0] == crc_bus.crc))
        else $error("checksum not appended");
    AST_CHIP_MAP: assert property (@(posedge core_clk) disable iff (!rstn)
        resp_active && chip_en && (nib_cnt_ff != crm_pkg::NIB_COUNT)
        |=> chip_level_ff == $past(sel_level))
        else $error("chip level off table");
    AST_PERIODIC_COLLECTION_MODE_ENTER: assert property (@(posedge core_clk) disable iff (!rstn)
        cmd_ok && is_periodic_collection_mode |=> periodic_collection_mode && !cmd_ready && !resp_active)
        else $error("periodic mode not entered");
endmodule

// ### crm_master_model.sv
// Purpose: bus master stand-in: offers command words, decodes response chips
// Assumes: CHIP_CYCLES equals the decoder's; chip one lands one edge after resp_active
// Notes:   a triple outside the symbol table decodes as 0 and sets sym_bad
`timescale 1ns/1ps
module crm_master_model
#(
    parameter int CHIP_CYCLES = 3
)
(
    input  wire logic        core_clk,
    input  wire logic        rstn,
    output logic             cmd_valid,
    output logic [31:0]      cmd_word,
    input  wire logic        cmd_ready,
    input  wire logic [1:0]  chip_level,
    input  wire logic        resp_active
);
    // own copy of the chip table, {chip1, chip2, chip3} per nibble
    logic [5:0] sym_ref [16] = '{6'h14, 6'h25, 6'h12, 6'h22, 6'h10, 6'h26, 6'h16, 6'h21,
                                 6'h28, 6'h24, 6'h1A, 6'h29, 6'h18, 6'h20, 6'h11, 6'h19};
    logic       sym_bad;

    // idle bus at time zero
    initial
    begin
        cmd_valid = 1'b0;
        cmd_word  = 32'h00000000;
        sym_bad   = 1'b0;
    end

    // whole 32-bit word held from a falling edge until ready is seen
    task automatic send(input logic [31:0] w, output logic taken);
        int n;
        n = 0;
        @(negedge core_clk);
        cmd_word  = w;
        cmd_valid = 1'b1;
        // ready only moves on rising edges, so the falling edge shows what the next edge takes
        while (cmd_ready !== 1'b1 && n < 100)
        begin
            n++;
            @(negedge core_clk);
        end
        taken = (n < 100);
        if (taken)
            @(posedge core_clk);
        @(negedge core_clk);
        cmd_valid = 1'b0;
        cmd_word  = ~w;   // released word must not look like the last one
    endtask

    // sample each chip mid-period, three chips make one nibble, msb nibble first
    task automatic get_resp(output logic [31:0] w, output logic got);
        int         n;
        logic [5:0] tri_ch;
        logic       hit;
        n      = 0;
        w      = 32'h00000000;
        got    = 1'b0;
        tri_ch = 6'h00;
        while (resp_active !== 1'b1 && n < 200)
        begin
            n++;
            @(negedge core_clk);
        end
        if (n < 200)
        begin
            got = 1'b1;
            @(posedge core_clk);
            repeat (CHIP_CYCLES / 2 + 1) @(negedge core_clk);
            for (int k = 0; k < 24; k++)
            begin
                tri_ch = {tri_ch[3:0], chip_level};
                if (k % 3 == 2)
                begin
                    hit = 1'b0;
                    for (int s = 0; s < 16; s++)
                        if (sym_ref[s] === tri_ch)
                        begin
                            w   = {w[27:0], 4'(s)};
                            hit = 1'b1;
                        end
                    if (!hit)
                    begin
                        w       = {w[27:0], 4'h0};
                        sym_bad = 1'b1;
                    end
                end
                repeat (CHIP_CYCLES) @(negedge core_clk);
            end
        end
    endtask
endmodule

// ### crm_response_and_command_decode_bench.sv
// Purpose: self-checking bench for the command decoder and response builder
// Assumes: chip period shortened to three core cycles
// Notes:   array bytes from 8'h80 are read-only, from 8'hE0 unreadable
`timescale 1ns/1ps
module crm_response_and_command_decode_bench;
    localparam int CHIPS = 3;
    logic        core_clk;
    logic        rstn;
    logic        cmd_valid;
    logic [31:0] cmd_word;
    logic        cmd_ready;
    logic [3:0]  node_address_register;
    logic [6:0]  reg_pair_address;
    logic        reg_wr_en;
    logic [7:0]  reg_byte_address;
    logic [7:0]  reg_wr_data;
    logic [1:0]  chip_level;
    logic        resp_active;
    logic        periodic_collection_mode;
    logic [7:0]  mem [256];
    wire  [7:0]  up_addr = {reg_pair_address, 1'b1};
    wire  [7:0]  lo_addr = {reg_pair_address, 1'b0};
    int          n_mismatch = 0;
    int          num_checks = 0;
    int          resp_cnt = 0;
    int          wr_cnt = 0;

    crm_cmd_resp #(.CHIP_CYCLES(CHIPS)) dut_u
    (
        .core_clk                 (core_clk),
        .rstn                     (rstn),
        .cmd_valid                (cmd_valid),
        .cmd_word                 (cmd_word),
        .cmd_ready                (cmd_ready),
        .node_address_register    (node_address_register),
        .reg_pair_address         (reg_pair_address),
        .upper_reg_data_byte      (mem[up_addr]),
        .lower_reg_data_byte      (mem[lo_addr]),
        .upper_readable           (up_addr < 8'hE0),
        .lower_readable           (lo_addr < 8'hE0),
        .reg_wr_en                (reg_wr_en),
        .reg_byte_address         (reg_byte_address),
        .reg_wr_data              (reg_wr_data),
        .chip_level               (chip_level),
        .resp_active              (resp_active),
        .periodic_collection_mode (periodic_collection_mode)
    );

    crm_master_model #(.CHIP_CYCLES(CHIPS)) master_u
    (
        .core_clk    (core_clk),
        .rstn        (rstn),
        .cmd_valid   (cmd_valid),
        .cmd_word    (cmd_word),
        .cmd_ready   (cmd_ready),
        .chip_level  (chip_level),
        .resp_active (resp_active)
    );

    // 50 MHz core clock
    initial
    begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    // register array: read-only bytes swallow writes; strobes and responses are counted
    always @(posedge core_clk)
    begin
        if (reg_wr_en === 1'b1)
        begin
            wr_cnt++;
            if (reg_byte_address < 8'h80)
                mem[reg_byte_address] <= reg_wr_data;
        end
    end
    always @(posedge resp_active)
        resp_cnt++;

    // ************************************************************
    // helpers
    // ************************************************************
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // augmented serial checksum: seed ones, 24 payload bits then 8 zeros
    function automatic logic [7:0] crc8(input logic [23:0] body);
        logic [7:0]  r;
        logic [31:0] m;
        r = 8'hFF;
        m = {body, 8'h00};
        for (int i = 31; i >= 0; i--)
            r = {r[6:0], m[i]} ^ (r[7] ? 8'h2F : 8'h00);
        return r;
    endfunction

    function automatic logic [31:0] mk(input logic [3:0] a, input logic [3:0] c,
                                       input logic [7:0] e, input logic [7:0] d);
        return {a, c, e, d, crc8({a, c, e, d})};
    endfunction

    // one command; body is the expected response without its checksum
    task automatic run_cmd(input logic [31:0] w, input logic want, input logic [23:0] body);
        logic [31:0] r;
        logic        got;
        logic        taken;
        int          n;
        int          rc;
        int          wc;
        rc = resp_cnt;
        wc = wr_cnt;
        master_u.send(w, taken);
        check("taken", 32'(taken), 32'h1);
        if (want)
        begin
            master_u.get_resp(r, got);
            check("answered", 32'(got), 32'h1);
            check("response", r, {body, crc8(body)});
            check("symbols", 32'(master_u.sym_bad), 32'h0);
            check("strobes", 32'(wr_cnt - wc), 32'(w[27:24] == 4'h8));
        end
        n = 0;
        while (cmd_ready !== 1'b1 && n < 400)
        begin
            n++;
            @(negedge core_clk);
        end
        check("back idle", 32'(n < 400), 32'h1);
        if (!want)
        begin
            check("silent", 32'(resp_cnt - rc), 32'h0);
            check("no write", 32'(wr_cnt - wc), 32'h0);
        end
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    // data changed after decode must not reach the response
    task automatic t_read();
        node_address_register = 4'h4;
        fork
            run_cmd(mk(4'h4, 4'h0, 8'h21, 8'hA5), 1'b1, {8'h40, mem[8'h21], mem[8'h20]});
            begin
                repeat (50) @(negedge core_clk);
                mem[8'h20] = 8'h77;
            end
        join
        check("pair addr", 32'(reg_pair_address), 32'h10);
        run_cmd(mk(4'h4, 4'h0, 8'hF2, 8'h00), 1'b1, {8'h40, 16'h0000});
    endtask

    // documented example word, then a write to a read-only byte
    task automatic t_write();
        node_address_register = 4'h1;
        run_cmd(32'h181186B0, 1'b1, {8'h18, 8'h86, mem[8'h10]});
        check("written byte", 32'(mem[8'h11]), 32'h86);
        run_cmd(mk(4'h1, 4'h8, 8'h90, 8'h33), 1'b1, {8'h18, mem[8'h91], mem[8'h90]});
        check("write addr", 32'(reg_byte_address), 32'h90);
        check("write data", 32'(reg_wr_data), 32'h33);
    endtask

    // bad checksum, foreign and global address, every reserved code
    task automatic t_drop();
        logic [3:0] codes [13] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7,
                                   4'h9, 4'hA, 4'hC, 4'hD, 4'hE, 4'hF};
        node_address_register = 4'h4;
        run_cmd(mk(4'h4, 4'h0, 8'h20, 8'h00) ^ 32'h1, 1'b0, 24'h0);
        run_cmd(mk(4'h3, 4'h8, 8'h05, 8'hEE), 1'b0, 24'h0);
        run_cmd(mk(4'h0, 4'h0, 8'h20, 8'h00), 1'b0, 24'h0);
        node_address_register = 4'h0;
        run_cmd(mk(4'h0, 4'h0, 8'h20, 8'h00), 1'b0, 24'h0);
        node_address_register = 4'h4;
        for (int i = 0; i < 13; i++)
            run_cmd(mk(4'h4, codes[i], 8'h05, 8'hEE), 1'b0, 24'h0);
        check("no store", 32'(mem[8'h05]), 32'h5F);
    endtask

    // periodic entry is final: no answer, port closed
    task automatic t_periodic();
        logic taken;
        int   rc;
        rc = resp_cnt;
        check("mode before", 32'(periodic_collection_mode), 32'h0);
        master_u.send(mk(4'h4, 4'hB, 8'h00, 8'h00), taken);
        check("mode cmd taken", 32'(taken), 32'h1);
        repeat (60) @(negedge core_clk);
        check("mode", 32'(periodic_collection_mode), 32'h1);
        check("ready low", 32'(cmd_ready), 32'h0);
        check("no answer", 32'(resp_cnt - rc), 32'h0);
        master_u.send(mk(4'h4, 4'h0, 8'h20, 8'h00), taken);
        check("refused", 32'(taken), 32'h0);
    endtask

    task automatic final_report();
        if (n_mismatch == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // main sequence
    initial
    begin
        for (int i = 0; i < 256; i++)
            mem[i] = 8'(i) ^ 8'h5A;
        rstn = 1'b0;
        node_address_register = 4'h4;
        repeat (20) @(negedge core_clk);
        rstn = 1'b1;
        t_read();
        t_write();
        t_drop();
        t_periodic();
        final_report();
    end

    // watchdog: the run needs some 1400 cycles
    initial
    begin
        #(20 * 20000);
        n_mismatch++;
        final_report();
    end
endmodule
